// ---- pdr_pkg.sv ----
// constants, timing and types shared by the pulse dialer design
package pdr_pkg;
    localparam int CLK_KHZ = 50000;
    localparam int TW = 26;
    localparam int DEBOUNCE_TIME_MS = 14;
    localparam int CLEAR_HOLD_TIME_MS = 300;
    localparam int INTERDIGIT_PAUSE_MS = 800;
    localparam int PULSE_PERIOD_MS = 100;
    localparam int SILENCE_OVERLAP_DELAY_MS = 10;
    localparam int MAKE_HI_PERMILLE = 334;
    localparam int MAKE_LO_PERMILLE = 400;
    localparam logic [TW-1:0] DEBOUNCE_CYC = TW'(DEBOUNCE_TIME_MS * CLK_KHZ);
    localparam logic [TW-1:0] HOLD_CYC = TW'(CLEAR_HOLD_TIME_MS * CLK_KHZ);
    localparam logic [TW-1:0] IDP_CYC = TW'(INTERDIGIT_PAUSE_MS * CLK_KHZ);
    localparam logic [TW-1:0] PERIOD_CYC = TW'(PULSE_PERIOD_MS * CLK_KHZ);
    localparam logic [TW-1:0] OVERLAP_CYC =
        TW'(SILENCE_OVERLAP_DELAY_MS * CLK_KHZ);
    localparam logic [TW-1:0] MAKE_HI_CYC =
        TW'(PULSE_PERIOD_MS * CLK_KHZ / 1000 * MAKE_HI_PERMILLE);
    localparam logic [TW-1:0] MAKE_LO_CYC =
        TW'(PULSE_PERIOD_MS * CLK_KHZ / 1000 * MAKE_LO_PERMILLE);
    localparam logic [3:0] SCAN_LAST = 4'h7;
    localparam int MEM_DIGITS = 32;
    localparam int FIFO_DEPTH = 8;
    localparam int DIG_W = 4;
    localparam logic [3:0] DIG_ZERO = 4'hA;
    localparam logic [3:0] DIG_STAR = 4'hB;
    localparam logic [3:0] DIG_HASH = 4'hC;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam int CTRL_CLR_BIT = 0;
    localparam int CTRL_INH_BIT = 1;
    localparam int STAT_STATE_LSB = 8;
    localparam int STAT_HOOK_BIT = 12;
    localparam int STAT_REDIAL_BIT = 13;
    localparam int STAT_REPLAY_BIT = 14;
    localparam int STAT_KEY_BIT = 15;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_PAUSE = 3'h1,
        ST_BREAK = 3'h3,
        ST_MAKE = 3'h2,
        ST_OVERLAP = 3'h6
    } pdr_state_type;
endpackage

// ---- pdr_dialer.sv ----
// pulse dialer with redial: keypad scan, digit fifo, outpulsing, mute
//
// Behaviour
// - on-hook: keypad ignored, oscillator stops once pulsing ends
// - off-hook: single pressed key digit stored
// - 32 digit memory, entry buffered from pulsing
// - pulse digits until all entered dialed
// - keep first 32 digits; redial after 300ms
// - star/hash first redials; other key restarts
// - power-up clear empties digit memory
// - valid key: one row with one column
// - on-hook: rows and columns held high
// - static keypad until key, then alternate scan
// - accept key after continuous debounce interval
// - ratio pin selects 33.4/66.6 or 40/60
// - mute from pre-digit pause to overlap end
// - on-hook: pulsing finishes within 300ms, stop
// - off-hook return gives falling mute edge
// - line released on make, low on break
`timescale 1ns/1ns
`default_nettype none

module pdr_fifo #(
    parameter int WIDTH = pdr_pkg::DIG_W,
    parameter int DEPTH = pdr_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic clr,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [LW-1:0] level;
    } pdr_fifo_type;
    pdr_fifo_type q;
    pdr_fifo_type d;
    logic push;
    logic pop;

    assign in_ready = (q.level != LW'(DEPTH));
    assign out_valid = (q.level != '0);
    assign out_data = q.mem[q.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp = (q.wp == PW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = (q.rp == PW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
        end
        if (push && !pop) begin
            d.level = q.level + 1'b1;
        end else if (pop && !push) begin
            d.level = q.level - 1'b1;
        end
        if (clr) begin
            d.wp = '0;
            d.rp = '0;
            d.level = '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end
endmodule

module pdr_dialer #(
    parameter int MEM_DIGITS = pdr_pkg::MEM_DIGITS,
    parameter int FIFO_DEPTH = pdr_pkg::FIFO_DEPTH,
    parameter logic [25:0] DEBOUNCE_CYC = pdr_pkg::DEBOUNCE_CYC,
    parameter logic [25:0] HOLD_CYC = pdr_pkg::HOLD_CYC,
    parameter logic [25:0] IDP_CYC = pdr_pkg::IDP_CYC,
    parameter logic [25:0] PERIOD_CYC = pdr_pkg::PERIOD_CYC,
    // make times follow the period, so a shortened period keeps the ratio
    parameter logic [25:0] MAKE_HI_CYC =
        26'(PERIOD_CYC * pdr_pkg::MAKE_HI_PERMILLE / 1000),
    parameter logic [25:0] MAKE_LO_CYC =
        26'(PERIOD_CYC * pdr_pkg::MAKE_LO_PERMILLE / 1000),
    parameter logic [25:0] OVERLAP_CYC = pdr_pkg::OVERLAP_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [3:0] keypad_row_line_in,
    output logic [3:0] keypad_row_line_out,
    output logic [3:0] keypad_row_line_oe,
    input wire logic [2:0] keypad_col_line_in,
    output logic [2:0] keypad_col_line_out,
    output logic [2:0] keypad_col_line_oe,
    input wire logic hook_detect_in,
    input wire logic ratio_sel_in,
    output logic line_break_oe,
    output logic mute_oe,
    output logic osc_run,
    input wire logic [3:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata
);
    localparam int TW = pdr_pkg::TW;
    localparam int CW = $clog2(MEM_DIGITS + 1);
    localparam int AW = $clog2(MEM_DIGITS);
    typedef struct packed {
        logic [8:0] s1;
        logic [8:0] s2;
        logic hook_prev;
        logic [TW-1:0] hook_cnt;
        logic redial_ok;
        logic first_key;
        logic scan_on;
        logic phase;
        logic [3:0] scan_cnt;
        logic col_seen;
        logic [1:0] col_idx;
        logic key_ok;
        logic [3:0] key_code;
        logic [TW-1:0] deb_cnt;
        logic key_done;
        logic [MEM_DIGITS-1:0][3:0] mem;
        logic [CW-1:0] cnt;
        logic replay;
        logic [CW-1:0] rp;
        pdr_pkg::pdr_state_type state;
        logic [TW-1:0] tmr;
        logic [3:0] pulses;
        logic inhibit;
        logic [TW-1:0] brk_run;
        logic [3:0] row_oe;
        logic [2:0] col_oe;
        logic pad_high;
        logic brk_oe;
        logic mute_oe;
        logic osc_run;
        logic [31:0] rdata;
    } pdr_regs_type;
    pdr_regs_type q;
    pdr_regs_type d;

    function automatic logic one_low(input logic [3:0] v);
        return ($countones(~v) == 1);
    endfunction

    function automatic logic [1:0] low_idx(input logic [3:0] v);
        low_idx = 2'h0;
        for (int i = 0; i < 4; i++) begin
            if (!v[i]) begin
                low_idx = 2'(i);
            end
        end
    endfunction

    function automatic logic [3:0] key_dec(input logic [1:0] r,
                                           input logic [1:0] c);
        if (r != 2'h3) begin
            key_dec = 4'(int'(r) * 3 + int'(c) + 1);
        end else if (c == 2'h0) begin
            key_dec = pdr_pkg::DIG_STAR;
        end else if (c == 2'h1) begin
            key_dec = pdr_pkg::DIG_ZERO;
        end else begin
            key_dec = pdr_pkg::DIG_HASH;
        end
    endfunction

    logic [3:0] rows;
    logic [3:0] cols;
    logic onhk;
    logic ratio_hi;
    logic off_edge;
    logic onhk_stop;
    logic [3:0] code;
    logic is_sym;
    logic key_fire;
    logic start_replay;
    logic [TW-1:0] make_cyc;
    logic [TW-1:0] brk_cyc;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [3:0] fifo_in_data;
    logic fifo_out_valid;
    logic [3:0] fifo_out_data;
    logic pop;

    assign rows = ~q.s2[3:0];
    assign cols = {1'b1, ~q.s2[6:4]};
    assign onhk = ~q.s2[7];
    assign ratio_hi = ~q.s2[8];
    assign off_edge = !onhk && q.hook_prev;
    assign onhk_stop = onhk && (q.hook_cnt == HOLD_CYC);
    assign code = key_dec(low_idx(rows), q.col_idx);
    assign is_sym = (q.key_code == pdr_pkg::DIG_STAR) ||
                    (q.key_code == pdr_pkg::DIG_HASH);
    assign key_fire = q.key_ok && !q.key_done && !q.replay && !onhk &&
                      (q.deb_cnt >= DEBOUNCE_CYC) && fifo_in_ready;
    assign start_replay = key_fire && is_sym && q.first_key &&
                          q.redial_ok && (q.cnt != '0);
    assign make_cyc = ratio_hi ? MAKE_HI_CYC : MAKE_LO_CYC;
    assign brk_cyc = PERIOD_CYC - make_cyc;
    // replayed digits and keyed digits share the fifo; keys wait meanwhile
    assign fifo_in_valid = q.replay || (key_fire && !is_sym);
    assign fifo_in_data = q.replay ? q.mem[q.rp[AW-1:0]] : q.key_code;

    pdr_fifo #(.WIDTH(4), .DEPTH(FIFO_DEPTH)) digit_fifo (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .clr(onhk_stop),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data)
    );

    always_comb begin
        d = q;
        pop = 1'b0;
        // kept inverted: the cleared sync stages read as idle lines and
        // on-hook, so no false key scan starts right after reset
        d.s1 = ~{ratio_sel_in, hook_detect_in, keypad_col_line_in,
                 keypad_row_line_in};
        d.s2 = q.s1;
        // software clear comes first so a hook event in the same cycle wins
        if (bus_wr && bus_addr == pdr_pkg::ADDR_CTRL) begin
            d.inhibit = bus_wdata[pdr_pkg::CTRL_INH_BIT];
            if (bus_wdata[pdr_pkg::CTRL_CLR_BIT]) begin
                d.cnt = '0;
                d.replay = 1'b0;
                d.redial_ok = 1'b0;
            end
        end
        d.hook_prev = onhk;
        if (onhk) begin
            if (q.hook_cnt < HOLD_CYC) begin
                d.hook_cnt = q.hook_cnt + 1'b1;
            end else if (q.cnt != '0) begin
                d.redial_ok = 1'b1;
            end
        end else begin
            d.hook_cnt = '0;
        end
        if (off_edge) begin
            d.first_key = 1'b1;
        end
        if (q.key_ok && q.deb_cnt < DEBOUNCE_CYC) begin
            d.deb_cnt = q.deb_cnt + 1'b1;
        end
        if (onhk) begin
            d.scan_on = 1'b0;
            d.key_ok = 1'b0;
            d.deb_cnt = '0;
            d.key_done = 1'b0;
        end else if (!q.scan_on) begin
            if (!(&cols)) begin
                d.scan_on = 1'b1;
                d.phase = 1'b0;
                d.scan_cnt = '0;
            end
        end else begin
            d.scan_cnt = q.scan_cnt + 1'b1;
            // sample late in the phase: two sync stages plus settling
            if (q.scan_cnt == pdr_pkg::SCAN_LAST) begin
                d.scan_cnt = '0;
                d.phase = !q.phase;
                if (!q.phase) begin
                    d.col_seen = one_low(cols);
                    d.col_idx = low_idx(cols);
                end else if (q.col_seen && one_low(rows)) begin
                    if (!q.key_ok || code != q.key_code) begin
                        d.key_ok = 1'b1;
                        d.key_code = code;
                        d.deb_cnt = '0;
                    end
                end else begin
                    d.key_ok = 1'b0;
                    d.deb_cnt = '0;
                    d.key_done = 1'b0;
                    d.scan_on = !(&rows);
                end
            end
        end
        if (key_fire) begin
            d.key_done = 1'b1;
            d.first_key = 1'b0;
            d.redial_ok = 1'b0;
            if (!is_sym) begin
                if (q.first_key) begin
                    d.mem[0] = q.key_code;
                    d.cnt = CW'(1);
                end else if (q.cnt < CW'(MEM_DIGITS)) begin
                    d.mem[q.cnt[AW-1:0]] = q.key_code;
                    d.cnt = q.cnt + 1'b1;
                end
            end
            if (start_replay) begin
                d.replay = 1'b1;
                d.rp = '0;
            end
        end
        if (q.replay && fifo_in_ready) begin
            d.rp = q.rp + 1'b1;
            if (q.rp + 1'b1 == q.cnt) begin
                d.replay = 1'b0;
            end
        end
        d.brk_run = (q.state == pdr_pkg::ST_BREAK) ? q.brk_run + 1'b1 : '0;
        if (q.tmr != '0) begin
            d.tmr = q.tmr - 1'b1;
        end
        case (q.state)
            pdr_pkg::ST_IDLE: begin
                if (off_edge) begin
                    d.state = pdr_pkg::ST_OVERLAP;
                    d.tmr = OVERLAP_CYC - 1'b1;
                end else if (fifo_out_valid && !q.inhibit) begin
                    pop = 1'b1;
                    d.pulses = fifo_out_data;
                    d.state = pdr_pkg::ST_PAUSE;
                    d.tmr = IDP_CYC - 1'b1;
                end
            end
            pdr_pkg::ST_PAUSE: begin
                if (q.tmr == '0) begin
                    d.state = pdr_pkg::ST_BREAK;
                    d.tmr = brk_cyc - 1'b1;
                end
            end
            pdr_pkg::ST_BREAK: begin
                if (q.tmr == '0) begin
                    d.pulses = q.pulses - 1'b1;
                    if (q.pulses != 4'h1) begin
                        d.state = pdr_pkg::ST_MAKE;
                        d.tmr = make_cyc - 1'b1;
                    end else if (fifo_out_valid && !q.inhibit) begin
                        pop = 1'b1;
                        d.pulses = fifo_out_data;
                        d.state = pdr_pkg::ST_PAUSE;
                        d.tmr = IDP_CYC - 1'b1;
                    end else begin
                        d.state = pdr_pkg::ST_OVERLAP;
                        d.tmr = OVERLAP_CYC - 1'b1;
                    end
                end
            end
            pdr_pkg::ST_MAKE: begin
                if (q.tmr == '0) begin
                    d.state = pdr_pkg::ST_BREAK;
                    d.tmr = brk_cyc - 1'b1;
                end
            end
            pdr_pkg::ST_OVERLAP: begin
                if (q.tmr == '0) begin
                    d.state = pdr_pkg::ST_IDLE;
                end
            end
            default: begin
                d.state = pdr_pkg::ST_IDLE;
            end
        endcase
        if (onhk_stop) begin
            d.state = pdr_pkg::ST_IDLE;
            d.replay = 1'b0;
        end
        d.pad_high = onhk;
        d.row_oe = (onhk || !d.scan_on || !d.phase) ? 4'hF : 4'h0;
        d.col_oe = (onhk || (d.scan_on && d.phase)) ? 3'h7 : 3'h0;
        d.brk_oe = (d.state == pdr_pkg::ST_BREAK);
        d.mute_oe = (d.state != pdr_pkg::ST_IDLE);
        d.osc_run = d.scan_on || d.replay ||
                    (d.state != pdr_pkg::ST_IDLE);
        d.rdata = '0;
        if (bus_rd) begin
            if (bus_addr == pdr_pkg::ADDR_CTRL) begin
                d.rdata[pdr_pkg::CTRL_INH_BIT] = q.inhibit;
            end else if (bus_addr == pdr_pkg::ADDR_STAT) begin
                d.rdata[CW-1:0] = q.cnt;
                d.rdata[pdr_pkg::STAT_STATE_LSB+:3] = q.state;
                d.rdata[pdr_pkg::STAT_HOOK_BIT] = onhk;
                d.rdata[pdr_pkg::STAT_REDIAL_BIT] = q.redial_ok;
                d.rdata[pdr_pkg::STAT_REPLAY_BIT] = q.replay;
                d.rdata[pdr_pkg::STAT_KEY_BIT] = q.key_ok;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign keypad_row_line_out = {4{q.pad_high}};
    assign keypad_row_line_oe = q.row_oe;
    assign keypad_col_line_out = {3{q.pad_high}};
    assign keypad_col_line_oe = q.col_oe;
    assign line_break_oe = q.brk_oe;
    assign mute_oe = q.mute_oe;
    assign osc_run = q.osc_run;
    assign bus_rdata = q.rdata;

    a_onhook_no_entry: assert property (@(posedge clk) disable iff (rst)
        onhk |-> !key_fire && !fifo_in_valid || q.replay)
        else $error("key taken while on-hook");
    a_pads_held_high: assert property (@(posedge clk) disable iff (rst)
        ce && onhk |=> (&keypad_row_line_oe) && (&keypad_col_line_oe) &&
        keypad_row_line_out[0])
        else $error("keypad lines not held high on-hook");
    a_debounce_held: assert property (@(posedge clk) disable iff (rst)
        key_fire |-> q.key_ok && q.deb_cnt >= DEBOUNCE_CYC)
        else $error("key accepted before debounce");
    a_break_length: assert property (@(posedge clk) disable iff (rst)
        ce && q.state == pdr_pkg::ST_BREAK &&
        d.state != pdr_pkg::ST_BREAK && !onhk_stop
        |-> q.brk_run == brk_cyc - 1'b1)
        else $error("break interval wrong length");
    a_mute_brackets: assert property (@(posedge clk) disable iff (rst)
        line_break_oe |-> mute_oe)
        else $error("break outside mute");
    a_redial_gate: assert property (@(posedge clk) disable iff (rst)
        ce && start_replay |=> q.replay && q.rp == '0)
        else $error("redial did not start");
    a_new_number: assert property (@(posedge clk) disable iff (rst)
        ce && key_fire && q.first_key && !is_sym |=> q.cnt == CW'(1))
        else $error("first digit did not restart number");
    a_hook_stop: assert property (@(posedge clk) disable iff (rst)
        ce && onhk_stop |=> q.state == pdr_pkg::ST_IDLE && !mute_oe)
        else $error("pulsing not stopped after on-hook hold");
    a_reconnect_edge: assert property (@(posedge clk) disable iff (rst)
        ce && off_edge && q.state == pdr_pkg::ST_IDLE |=> mute_oe)
        else $error("no mute edge on return off-hook");
    c_key_stored: cover property (@(posedge clk) disable iff (rst)
        key_fire && !is_sym);
    c_redial: cover property (@(posedge clk) disable iff (rst)
        start_replay);
    c_break_make: cover property (@(posedge clk) disable iff (rst)
        q.state == pdr_pkg::ST_BREAK ##1 q.state == pdr_pkg::ST_MAKE);
endmodule

`default_nettype wire

// ---- pdr_keypad.sv ----
// keypad matrix model: pull-ups on every line, one key that can be held
`timescale 1ns/1ns
`default_nettype none
module pdr_keypad (
    input wire logic [3:0] row_out,
    input wire logic [3:0] row_oe,
    input wire logic [2:0] col_out,
    input wire logic [2:0] col_oe,
    input wire logic pressed,
    input wire logic [1:0] key_row,
    input wire logic [1:0] key_col,
    output logic [3:0] row_in,
    output logic [2:0] col_in
);
    logic [3:0] row_wire;
    logic [2:0] col_wire;
    logic joined;
    // a line nobody pulls low floats up, never holds its last value
    assign row_wire = ~(row_oe & ~row_out);
    assign col_wire = ~(col_oe & ~col_out);
    assign joined = row_wire[key_row] & col_wire[key_col];
    always_comb begin
        row_in = row_wire;
        col_in = col_wire;
        if (pressed) begin
            row_in[key_row] = joined;
            col_in[key_col] = joined;
        end
    end
endmodule
`default_nettype wire

// ---- tb_pdr_dialer.sv ----
// self-checking bench for the pulse dialer
`timescale 1ns/1ns
`default_nettype none
module tb_pdr_dialer;
    localparam int BRK_HI = 20;
    localparam int BRK_LO = 18;
    logic clk, rst, ce, hook, ratio, pressed, bus_wr, bus_rd;
    logic [1:0] key_row, key_col;
    logic [3:0] row_in, row_out, row_oe, bus_addr;
    logic [2:0] col_in, col_out, col_oe;
    logic line_oe, mute_oe, osc_run;
    logic [31:0] bus_wdata, bus_rdata, rd;
    int err_total, compares, n, hi;
    // make times derive from the period: 10 or 12 of 30 cycles
    pdr_dialer #(.DEBOUNCE_CYC(26'h28), .HOLD_CYC(26'h64),
        .IDP_CYC(26'h32), .PERIOD_CYC(26'h1E), .OVERLAP_CYC(26'h8)) dut (
        .clk(clk), .rst(rst), .ce(ce),
        .keypad_row_line_in(row_in), .keypad_row_line_out(row_out),
        .keypad_row_line_oe(row_oe), .keypad_col_line_in(col_in),
        .keypad_col_line_out(col_out), .keypad_col_line_oe(col_oe),
        .hook_detect_in(hook), .ratio_sel_in(ratio),
        .line_break_oe(line_oe), .mute_oe(mute_oe), .osc_run(osc_run),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata));
    pdr_keypad pad (.row_out(row_out), .row_oe(row_oe), .col_out(col_out),
        .col_oe(col_oe), .pressed(pressed), .key_row(key_row),
        .key_col(key_col), .row_in(row_in), .col_in(col_in));
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask
    task automatic bus_read(input logic [3:0] a);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 rd = bus_rdata;
    endtask
    // hold long enough for debounce plus scan latency, then release
    task automatic press(input logic [1:0] r, input logic [1:0] c);
        @(posedge clk);
        pressed <= 1'b1;
        key_row <= r;
        key_col <= c;
        repeat (120) @(posedge clk);
        pressed <= 1'b0;
        repeat (40) @(posedge clk);
    endtask
    // counts breaks and break cycles until the line has been quiet a while
    task automatic pulses;
        int quiet, k;
        logic prev;
        n = 0;
        hi = 0;
        quiet = 0;
        prev = 0;
        for (k = 0; k < 3000 && !mute_oe; k++) @(posedge clk);
        for (k = 0; k < 5000 && quiet < 100; k++) begin
            @(posedge clk);
            #1;
            if (line_oe && !prev) n++;
            if (line_oe) hi++;
            prev = line_oe;
            quiet = mute_oe ? 0 : quiet + 1;
        end
    endtask
    task automatic s_onhook;
        check("pads", {row_in, col_in}, 7'h7F);
        press(2'h0, 2'h1);
        check("osc", osc_run, 1'b0);
        bus_read(pdr_pkg::ADDR_STAT);
        check("count", rd[5:0], 6'h00);
        check("hookbit", rd[12], 1'b1);
        bus_read(4'h8);
        check("unmapped", rd, 32'h0);
    endtask
    task automatic s_dial;
        @(posedge clk);
        hook <= 1'b0;
        // let the off-hook mute pulse run out before looking
        repeat (20) @(posedge clk);
        #1;
        check("static rows", row_in, 4'h0);
        check("idle osc", osc_run, 1'b0);
        fork
            begin
                press(2'h0, 2'h1);
                press(2'h3, 2'h1);
            end
            pulses;
        join
        check("breaks", n, 32'd12);
        check("break cyc", hi, 32'd12 * BRK_HI);
        bus_read(pdr_pkg::ADDR_STAT);
        check("count", rd[5:0], 6'h02);
    endtask
    task automatic hang_up(input logic [1:0] r, input logic [1:0] c);
        int k;
        @(posedge clk);
        hook <= 1'b1;
        repeat (150) @(posedge clk);
        bus_read(pdr_pkg::ADDR_STAT);
        check("redial ok", rd[13], 1'b1);
        @(posedge clk);
        hook <= 1'b0;
        for (k = 0; k < 10 && !mute_oe; k++) begin
            @(posedge clk);
            #1;
        end
        check("mute up", mute_oe, 1'b1);
        for (k = 0; k < 20 && mute_oe; k++) begin
            @(posedge clk);
            #1;
        end
        check("mute fell", mute_oe, 1'b0);
        fork
            press(r, c);
            pulses;
        join
    endtask
    task automatic s_redial;
        @(posedge clk);
        ratio <= 1'b0;
        hang_up(2'h3, 2'h0);
        check("replay", n, 32'd12);
        check("break lo", hi, 32'd12 * BRK_LO);
        hang_up(2'h0, 2'h2);
        check("new number", n, 32'd3);
        bus_read(pdr_pkg::ADDR_STAT);
        check("new count", rd[5:0], 6'h01);
    endtask
    task automatic s_abort;
        int k;
        fork
            press(2'h1, 2'h1);
        join_none
        for (k = 0; k < 500 && !mute_oe; k++) @(posedge clk);
        repeat (40) @(posedge clk);
        hook <= 1'b1;
        repeat (130) @(posedge clk);
        #1;
        check("quiet", {line_oe, mute_oe, osc_run}, 3'h0);
        wait fork;
    endtask
    task automatic s_clear;
        bus_write(pdr_pkg::ADDR_CTRL, 32'h3);
        bus_read(pdr_pkg::ADDR_CTRL);
        check("ctrl", rd, 32'h2);
        bus_write(pdr_pkg::ADDR_CTRL, 32'h0);
        bus_read(pdr_pkg::ADDR_STAT);
        check("cleared", rd[5:0], 6'h00);
        // a write while the clock enable is low must not land
        @(posedge clk);
        ce <= 1'b0;
        bus_write(pdr_pkg::ADDR_CTRL, 32'h2);
        ce <= 1'b1;
        bus_read(pdr_pkg::ADDR_CTRL);
        check("frozen", rd, 32'h0);
        // redial permit is still up here; power-up clear must drop it
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        bus_read(pdr_pkg::ADDR_STAT);
        check("pwr clear", {rd[13], rd[5:0]}, 7'h00);
    endtask
    initial begin
        err_total = 0;
        compares = 0;
        rst = 1'b1;
        ce = 1'b1;
        hook = 1'b1;
        ratio = 1'b1;
        pressed = 1'b0;
        key_row = 2'h0;
        key_col = 2'h0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_addr = 4'h0;
        bus_wdata = 32'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        s_onhook;
        s_dial;
        s_redial;
        s_abort;
        s_clear;
        test_done;
    end
    // whole run is about 2500 cycles
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        test_done;
    end
endmodule
`default_nettype wire
